// *** rtl/dwpef_pkg.sv ***
// Shared constants and types for the width-packing DMA engine and event flags
package dwpef_pkg;
   localparam int NUM_CH = 8;
   localparam int CFG_W = 15;
   localparam int CNT_W = 16;
   // Register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_CLEAR = 8'h04;
   localparam logic [7:0] OFF_CFG0 = 8'h08;
   localparam logic [7:0] CH_STRIDE = 8'h14;
   localparam logic [7:0] REL_CFG = 8'h00;
   localparam logic [7:0] REL_COUNT = 8'h04;
   localparam logic [7:0] REL_PADDR = 8'h08;
   localparam logic [7:0] REL_MADDR = 8'h0c;
   // Channel config field positions
   localparam int CFG_EN = 0;
   localparam int CFG_DONE_IE = 1;
   localparam int CFG_HALF_IE = 2;
   localparam int CFG_ERR_IE = 3;
   localparam int CFG_DIR = 4;
   localparam int CFG_CIRC = 5;
   localparam int CFG_PSTEP = 6;
   localparam int CFG_MSTEP = 7;
   localparam int CFG_PW_LO = 8;
   localparam int CFG_MW_LO = 10;
   localparam int CFG_M2M = 14;
   // Flag positions inside a channel's 4-bit group
   localparam int FLG_ANY = 0;
   localparam int FLG_DONE = 1;
   localparam int FLG_HALF = 2;
   localparam int FLG_ERR = 3;
   localparam int FLG_GRP = 4;
   // Reset values
   localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;
   localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] STATUS_RST = 32'h0000_0000;
   // AHB transfer types
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {
      WID_8 = 2'b00,
      WID_16 = 2'b01,
      WID_32 = 2'b10,
      WID_RSV = 2'b11
   } dwpef_width_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_RD_ADR = 3'b010,
      ST_RD_DAT = 3'b011,
      ST_WR_ADR = 3'b100,
      ST_WR_DAT = 3'b101
   } dwpef_state_t;
endpackage

// *** rtl/dwpef_evt_if.sv ***
// Event, clear and flag signals between the engine and the flag store
`timescale 1ns/1ps
interface dwpef_evt_if;
   import dwpef_pkg::*;
   logic [NUM_CH-1:0] set_err;
   logic [NUM_CH-1:0] set_half;
   logic [NUM_CH-1:0] set_done;
   logic [31:0] clr;
   logic [NUM_CH-1:0] ie_err;
   logic [NUM_CH-1:0] ie_half;
   logic [NUM_CH-1:0] ie_done;
   logic [31:0] flags;
   logic [NUM_CH-1:0] irq;
   modport core (output set_err, set_half, set_done, clr, ie_err, ie_half, ie_done,
                 input flags, irq);
   modport store (input set_err, set_half, set_done, clr, ie_err, ie_half, ie_done,
                  output flags, irq);
endinterface

// *** rtl/dwpef_pack.sv ***
// Source item extraction, width conversion and byte-lane replication
`timescale 1ns/1ps
module dwpef_pack (
   // Widths and source lane
   input wire dwpef_pkg::dwpef_width_t i_src_w,
   input wire dwpef_pkg::dwpef_width_t i_dst_w,
   input wire logic [1:0] i_src_lane,
   // Data
   input wire logic [31:0] i_rdata,
   output logic [31:0] o_wdata
);
   import dwpef_pkg::*;
   logic [31:0] item;

   always_comb begin
      // Narrow source items are zero-extended
      case (i_src_w)
         WID_8: item = {24'h000000, i_rdata[{i_src_lane, 3'b000} +: 8]};
         WID_16: item = {16'h0000, i_rdata[{i_src_lane[1], 4'h0} +: 16]};
         default: item = i_rdata;
      endcase
      // Truncate to destination width, then copy over the unused lanes
      case (i_dst_w)
         WID_8: o_wdata = {4{item[7:0]}};
         WID_16: o_wdata = {2{item[15:0]}};
         default: o_wdata = item;
      endcase
   end
endmodule

// *** rtl/dwpef_flags.sv ***
// Per-channel event flags with write-one clear and gated channel requests
`timescale 1ns/1ps
module dwpef_flags (
   // Clock and synchronised reset
   input wire logic clk,
   input wire logic rst_b,
   // Events and flags
   dwpef_evt_if.store ev
);
   import dwpef_pkg::*;
   logic [31:0] flags_q;
   logic [31:0] next_flags;
   logic [NUM_CH-1:0] irq_q;
   logic [NUM_CH-1:0] next_irq;

   always_comb begin
      next_flags = flags_q;
      next_irq = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         // Clear first, then set, so a same-cycle event survives
         if (ev.clr[FLG_GRP*c + FLG_ANY]) begin
            next_flags[FLG_GRP*c +: FLG_GRP] = 4'h0;
         end
         if (ev.clr[FLG_GRP*c + FLG_ERR]) begin
            next_flags[FLG_GRP*c + FLG_ERR] = 1'b0;
         end
         if (ev.clr[FLG_GRP*c + FLG_HALF]) begin
            next_flags[FLG_GRP*c + FLG_HALF] = 1'b0;
         end
         if (ev.clr[FLG_GRP*c + FLG_DONE]) begin
            next_flags[FLG_GRP*c + FLG_DONE] = 1'b0;
         end
         if (ev.set_err[c]) begin
            next_flags[FLG_GRP*c + FLG_ERR] = 1'b1;
         end
         if (ev.set_half[c]) begin
            next_flags[FLG_GRP*c + FLG_HALF] = 1'b1;
         end
         if (ev.set_done[c]) begin
            next_flags[FLG_GRP*c + FLG_DONE] = 1'b1;
         end
         if (ev.set_err[c] || ev.set_half[c] || ev.set_done[c]) begin
            next_flags[FLG_GRP*c + FLG_ANY] = 1'b1;
         end
         next_irq[c] = (next_flags[FLG_GRP*c + FLG_ERR] & ev.ie_err[c])
                     | (next_flags[FLG_GRP*c + FLG_HALF] & ev.ie_half[c])
                     | (next_flags[FLG_GRP*c + FLG_DONE] & ev.ie_done[c]);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= STATUS_RST;
         irq_q <= '0;
      end else begin
         flags_q <= next_flags;
         irq_q <= next_irq;
      end
   end

   assign ev.flags = flags_q;
   assign ev.irq = irq_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
      clear_one_a: assert property (
         ev.clr[FLG_GRP*c + FLG_HALF] && !ev.set_half[c] && !ev.clr[FLG_GRP*c + FLG_ANY]
         && !ev.set_err[c] && !ev.clr[FLG_GRP*c + FLG_ERR]
         |=> !flags_q[FLG_GRP*c + FLG_HALF]
            && $stable(flags_q[FLG_GRP*c + FLG_ERR]))
         else $error("half clear did not act alone");
      clear_all_a: assert property (
         ev.clr[FLG_GRP*c + FLG_ANY] && !ev.set_err[c] && !ev.set_half[c] && !ev.set_done[c]
         |=> flags_q[FLG_GRP*c +: FLG_GRP] == 4'h0)
         else $error("channel clear left a flag set");
      any_flag_a: assert property (
         ev.set_err[c] || ev.set_half[c] || ev.set_done[c]
         |=> flags_q[FLG_GRP*c + FLG_ANY])
         else $error("channel any-flag not set by event");
      irq_gate_a: assert property (
         ev.set_err[c] && ev.ie_err[c] |=> irq_q[c] ##0 flags_q[FLG_GRP*c + FLG_ERR])
         else $error("enabled error did not raise channel request");
      set_wins_a: assert property (
         ev.set_done[c] && ev.clr[FLG_GRP*c + FLG_ANY] |=> flags_q[FLG_GRP*c + FLG_DONE])
         else $error("clear beat a same-cycle event");
   end
endmodule

// *** rtl/dwpef_top.sv ***
// Eight-channel DMA engine: width packing, lane replication, errors and flags
// Behaviour
// - Narrow source written zero-extended to wider destination
// - Wide source to byte keeps low byte
// - Word source to halfword keeps low half
// - Source and destination addresses step independently
// - Equal widths copy items unchanged
// - Narrow writes set size, replicate over lanes
// - Bus error disables the faulty channel
// - Bus error sets error flag, gated request
// - Three gated sources merged per channel request
// - Status holds four flags per channel group
// - Flags hardware-set, read-only, cleared by writing one
// - Any event sets channel any-flag
// - Single clear bit clears only its flag
// - Channel clear bit clears all four flags
// - Half count transferred sets half flag
// - Last item transferred sets done flag
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module dwpef_top (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // APB register slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // AHB master
   output logic [31:0] O_HADDR,
   output logic [1:0] O_HTRANS,
   output logic O_HWRITE,
   output logic [2:0] O_HSIZE,
   output logic [31:0] O_HWDATA,
   input wire logic [31:0] I_HRDATA,
   input wire logic I_HREADY,
   input wire logic I_HRESP,
   // Channel requests
   input wire logic [dwpef_pkg::NUM_CH-1:0] I_CH_REQ,
   output logic [dwpef_pkg::NUM_CH-1:0] O_CH_ACK,
   output logic [dwpef_pkg::NUM_CH-1:0] O_CH_IRQ
);
   import dwpef_pkg::*;

   function automatic logic [5:0] reg_decode(input logic [7:0] a);
      logic [5:0] r;
      r = 6'h00;
      for (int c = 0; c < NUM_CH; c++) begin
         for (int k = 0; k < 4; k++) begin
            if (a == 8'(OFF_CFG0 + CH_STRIDE * 8'(c) + (8'(k) << 2))) begin
               r = {1'b1, 3'(c), 2'(k)};
            end
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] step_bytes(input dwpef_width_t w);
      case (w)
         WID_8: step_bytes = 32'h0000_0001;
         WID_16: step_bytes = 32'h0000_0002;
         default: step_bytes = 32'h0000_0004;
      endcase
   endfunction

   // Low address bits below the item size are ignored on the bus
   function automatic logic [31:0] align(input logic [31:0] a, input dwpef_width_t w);
      case (w)
         WID_8: align = a;
         WID_16: align = {a[31:1], 1'b0};
         default: align = {a[31:2], 2'b00};
      endcase
   endfunction

   logic rst_meta_b;
   logic rst_b;
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rst_meta_b <= 1'b0;
         rst_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_b <= rst_meta_b;
      end
   end

   dwpef_evt_if ev ();

   // Channel state
   logic [CFG_W-1:0] cfg_q [NUM_CH];
   logic [CFG_W-1:0] next_cfg [NUM_CH];
   logic [CNT_W-1:0] cnt_q [NUM_CH];
   logic [CNT_W-1:0] next_cnt [NUM_CH];
   logic [CNT_W-1:0] init_q [NUM_CH];
   logic [CNT_W-1:0] next_init [NUM_CH];
   logic [31:0] pbase_q [NUM_CH];
   logic [31:0] next_pbase [NUM_CH];
   logic [31:0] mbase_q [NUM_CH];
   logic [31:0] next_mbase [NUM_CH];
   logic [31:0] pcur_q [NUM_CH];
   logic [31:0] next_pcur [NUM_CH];
   logic [31:0] mcur_q [NUM_CH];
   logic [31:0] next_mcur [NUM_CH];
   // Engine state
   dwpef_state_t state_q, next_state;
   logic [2:0] act_q, next_act;
   logic [31:0] rdata_q, next_rdata;
   logic [31:0] haddr_q, next_haddr;
   logic [1:0] htrans_q, next_htrans;
   logic hwrite_q, next_hwrite;
   logic [2:0] hsize_q, next_hsize;
   logic [31:0] hwdata_q, next_hwdata;
   logic [NUM_CH-1:0] ack_q, next_ack;
   logic [31:0] prdata_q, next_prdata;
   logic pslverr_q, next_pslverr;
   // Decoded and derived values
   logic [5:0] dec;
   logic apb_wr, apb_setup;
   logic item_done, err_evt, pick_ok;
   logic [2:0] pick_ch;
   dwpef_width_t pw, mw, src_w, dst_w;
   logic [31:0] src_addr, dst_addr, p_next_addr, m_next_addr, packed_data;
   logic [CNT_W-1:0] cnt_dec;

   assign dec = reg_decode(I_PADDR);
   assign apb_setup = I_PSEL && !I_PENABLE;
   assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
   assign item_done = (state_q == ST_WR_DAT) && I_HREADY && !I_HRESP;
   assign err_evt = ((state_q == ST_RD_DAT) || (state_q == ST_WR_DAT)) && I_HRESP;

   always_comb begin
      pw = dwpef_width_t'(cfg_q[act_q][CFG_PW_LO +: 2]);
      mw = dwpef_width_t'(cfg_q[act_q][CFG_MW_LO +: 2]);
      // Direction bit picks which side is read
      src_w = cfg_q[act_q][CFG_DIR] ? mw : pw;
      dst_w = cfg_q[act_q][CFG_DIR] ? pw : mw;
      src_addr = cfg_q[act_q][CFG_DIR] ? mcur_q[act_q] : pcur_q[act_q];
      dst_addr = cfg_q[act_q][CFG_DIR] ? pcur_q[act_q] : mcur_q[act_q];
      p_next_addr = pcur_q[act_q] + step_bytes(pw);
      m_next_addr = mcur_q[act_q] + step_bytes(mw);
      cnt_dec = cnt_q[act_q] - 16'h0001;
      // Lowest numbered ready channel wins
      pick_ok = 1'b0;
      pick_ch = 3'h0;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (cfg_q[c][CFG_EN] && cnt_q[c] != COUNT_RST && (I_CH_REQ[c] || cfg_q[c][CFG_M2M])) begin
            pick_ok = 1'b1;
            pick_ch = 3'(c);
         end
      end
   end

   dwpef_pack u_pack (
      .i_src_w(src_w),
      .i_dst_w(dst_w),
      .i_src_lane(src_addr[1:0]),
      .i_rdata(rdata_q),
      .o_wdata(packed_data)
   );

   always_comb begin
      next_cfg = cfg_q;
      next_cnt = cnt_q;
      next_init = init_q;
      next_pbase = pbase_q;
      next_mbase = mbase_q;
      next_pcur = pcur_q;
      next_mcur = mcur_q;
      // Count and address writes are ignored while the channel is enabled
      if (apb_wr && dec[5]) begin
         case (dec[1:0])
            2'h0: begin
               next_cfg[dec[4:2]] = I_PWDATA[CFG_W-1:0];
               if (!cfg_q[dec[4:2]][CFG_EN] && I_PWDATA[CFG_EN]) begin
                  next_pcur[dec[4:2]] = pbase_q[dec[4:2]];
                  next_mcur[dec[4:2]] = mbase_q[dec[4:2]];
               end
            end
            2'h1: if (!cfg_q[dec[4:2]][CFG_EN]) begin
               next_cnt[dec[4:2]] = I_PWDATA[CNT_W-1:0];
               next_init[dec[4:2]] = I_PWDATA[CNT_W-1:0];
            end
            2'h2: if (!cfg_q[dec[4:2]][CFG_EN]) begin
               next_pbase[dec[4:2]] = I_PWDATA;
               next_pcur[dec[4:2]] = I_PWDATA;
            end
            default: if (!cfg_q[dec[4:2]][CFG_EN]) begin
               next_mbase[dec[4:2]] = I_PWDATA;
               next_mcur[dec[4:2]] = I_PWDATA;
            end
         endcase
      end
      if (item_done) begin
         next_cnt[act_q] = cnt_dec;
         if (cfg_q[act_q][CFG_PSTEP]) begin
            next_pcur[act_q] = p_next_addr;
         end
         if (cfg_q[act_q][CFG_MSTEP]) begin
            next_mcur[act_q] = m_next_addr;
         end
      end
      if (err_evt) begin
         next_cfg[act_q][CFG_EN] = 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge rst_b) begin
      if (!rst_b) begin
         for (int c = 0; c < NUM_CH; c++) begin
            cfg_q[c] <= CFG_RST;
            cnt_q[c] <= COUNT_RST;
            init_q[c] <= COUNT_RST;
            pbase_q[c] <= ADDR_RST;
            mbase_q[c] <= ADDR_RST;
            pcur_q[c] <= ADDR_RST;
            mcur_q[c] <= ADDR_RST;
         end
      end else begin
         cfg_q <= next_cfg;
         cnt_q <= next_cnt;
         init_q <= next_init;
         pbase_q <= next_pbase;
         mbase_q <= next_mbase;
         pcur_q <= next_pcur;
         mcur_q <= next_mcur;
      end
   end

   always_comb begin
      next_state = state_q;
      next_act = act_q;
      next_rdata = rdata_q;
      next_haddr = haddr_q;
      next_htrans = htrans_q;
      next_hwrite = hwrite_q;
      next_hsize = hsize_q;
      next_hwdata = hwdata_q;
      next_ack = '0;
      case (state_q)
         ST_IDLE: if (pick_ok) begin
            next_act = pick_ch;
            next_state = ST_LOAD;
         end
         ST_LOAD: begin
            next_htrans = HTRANS_NONSEQ;
            next_haddr = align(src_addr, src_w);
            next_hwrite = 1'b0;
            next_hsize = {1'b0, src_w};
            next_state = ST_RD_ADR;
         end
         ST_RD_ADR: if (I_HREADY) begin
            next_htrans = HTRANS_IDLE;
            next_state = ST_RD_DAT;
         end
         ST_RD_DAT: if (I_HRESP) begin
            next_state = ST_IDLE;
         end else if (I_HREADY) begin
            next_rdata = I_HRDATA;
            next_htrans = HTRANS_NONSEQ;
            next_haddr = align(dst_addr, dst_w);
            next_hwrite = 1'b1;
            next_hsize = {1'b0, dst_w};
            next_state = ST_WR_ADR;
         end
         ST_WR_ADR: if (I_HREADY) begin
            next_htrans = HTRANS_IDLE;
            next_hwdata = packed_data;
            next_state = ST_WR_DAT;
         end
         ST_WR_DAT: if (I_HRESP || I_HREADY) begin
            next_hwrite = 1'b0;
            next_state = ST_IDLE;
            next_ack[act_q] = !I_HRESP;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         act_q <= 3'h0;
         rdata_q <= 32'h0000_0000;
         haddr_q <= ADDR_RST;
         htrans_q <= HTRANS_IDLE;
         hwrite_q <= 1'b0;
         hsize_q <= 3'h0;
         hwdata_q <= 32'h0000_0000;
         ack_q <= '0;
      end else begin
         state_q <= next_state;
         act_q <= next_act;
         rdata_q <= next_rdata;
         haddr_q <= next_haddr;
         htrans_q <= next_htrans;
         hwrite_q <= next_hwrite;
         hsize_q <= next_hsize;
         hwdata_q <= next_hwdata;
         ack_q <= next_ack;
      end
   end

   // Flag events and enables
   always_comb begin
      ev.set_err = '0;
      ev.set_half = '0;
      ev.set_done = '0;
      ev.set_err[act_q] = err_evt;
      ev.set_half[act_q] = item_done && cnt_dec == {1'b0, init_q[act_q][CNT_W-1:1]};
      ev.set_done[act_q] = item_done && cnt_dec == COUNT_RST;
      ev.clr = (apb_wr && I_PADDR == OFF_CLEAR) ? I_PWDATA : 32'h0000_0000;
      for (int c = 0; c < NUM_CH; c++) begin
         ev.ie_err[c] = cfg_q[c][CFG_ERR_IE];
         ev.ie_half[c] = cfg_q[c][CFG_HALF_IE];
         ev.ie_done[c] = cfg_q[c][CFG_DONE_IE];
      end
   end

   dwpef_flags u_flags (
      .clk(I_CLK),
      .rst_b(rst_b),
      .ev(ev)
   );

   // Read data is sampled in the setup cycle so it comes from a flop
   always_comb begin
      next_prdata = prdata_q;
      next_pslverr = pslverr_q;
      if (apb_setup) begin
         next_prdata = 32'h0000_0000;
         next_pslverr = !(dec[5] || I_PADDR == OFF_STATUS || I_PADDR == OFF_CLEAR);
         if (I_PADDR == OFF_STATUS) begin
            next_prdata = ev.flags;
         end else if (dec[5]) begin
            case (dec[1:0])
               2'h0: next_prdata = {17'h00000, cfg_q[dec[4:2]]};
               2'h1: next_prdata = {16'h0000, cnt_q[dec[4:2]]};
               2'h2: next_prdata = pbase_q[dec[4:2]];
               default: next_prdata = mbase_q[dec[4:2]];
            endcase
         end
      end
   end

   always_ff @(posedge I_CLK or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= next_prdata;
         pslverr_q <= next_pslverr;
      end
   end

   assign O_PRDATA = prdata_q;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = pslverr_q;
   assign O_HADDR = haddr_q;
   assign O_HTRANS = htrans_q;
   assign O_HWRITE = hwrite_q;
   assign O_HSIZE = hsize_q;
   assign O_HWDATA = hwdata_q;
   assign O_CH_ACK = ack_q;
   assign O_CH_IRQ = ev.irq;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!rst_b);

   zero_extend_a: assert property (
      state_q == ST_WR_DAT && src_w == WID_8 && dst_w == WID_32 |-> O_HWDATA[31:8] == 24'h0)
      else $error("narrow item not zero-extended");
   byte_trunc_a: assert property (
      state_q == ST_WR_DAT && src_w == WID_32 && dst_w == WID_8 |-> O_HWDATA[7:0] == rdata_q[7:0])
      else $error("byte destination lost low byte");
   half_trunc_a: assert property (
      state_q == ST_WR_DAT && src_w == WID_32 && dst_w == WID_16
      |-> O_HWDATA == {2{rdata_q[15:0]}})
      else $error("halfword destination wrong");
   step_addr_a: assert property (
      item_done && cfg_q[act_q][CFG_PSTEP]
      |=> pcur_q[act_q] - $past(pcur_q[act_q])
         == ($past(pw) == WID_8 ? 32'h1 : $past(pw) == WID_16 ? 32'h2 : 32'h4))
      else $error("peripheral address did not step");
   equal_copy_a: assert property (
      state_q == ST_WR_DAT && src_w == WID_32 && dst_w == WID_32 |-> O_HWDATA == rdata_q)
      else $error("equal width copy altered");
   lane_rep_a: assert property (
      state_q == ST_WR_DAT && O_HSIZE == 3'h0 |-> O_HWDATA == {4{O_HWDATA[7:0]}})
      else $error("byte not replicated across lanes");
   err_disable_a: assert property (
      err_evt |=> !cfg_q[act_q][CFG_EN] ##0 state_q == ST_IDLE)
      else $error("faulty channel still enabled");
   err_flag_a: assert property (
      err_evt |=> ev.flags[FLG_GRP*act_q + FLG_ERR])
      else $error("error flag not set");
   done_flag_a: assert property (
      item_done && cnt_dec == COUNT_RST |=> ev.flags[FLG_GRP*act_q + FLG_DONE])
      else $error("done flag not set on last item");
   item_cov: cover property (state_q == ST_WR_DAT ##1 state_q == ST_IDLE);
   err_cov: cover property (err_evt);
   half_cov: cover property (ev.set_half != '0);
   rep_cov: cover property (state_q == ST_WR_DAT && O_HSIZE == 3'h1);
endmodule

// *** dv/dwpef_ahb_mem.sv ***
// AHB memory slave that ignores transfer size, with wait and error responses
`timescale 1ns/1ps
module dwpef_ahb_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Insert one wait state per data phase
   input wire logic i_slow,
   // AHB slave side
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   output logic [31:0] o_hrdata,
   output logic o_hready,
   output logic o_hresp
);
   logic [31:0] mem [16];
   logic [31:0] a;
   logic [31:0] last;
   logic pend, w, err, ws;
   // Upper half of the map is reserved: two-cycle error response
   assign o_hresp = pend && err;
   assign o_hready = !pend || ws || !(i_slow || err);
   // Released data lines show a changing pattern, not the last word
   assign o_hrdata = (pend && !w && !err) ? mem[a[5:2]] : ~last;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend <= 1'b0;
         ws <= 1'b0;
         last <= 32'h0;
      end else if (o_hready) begin
         // Size is ignored: whole word at aligned address
         if (pend && w && !err) mem[a[5:2]] <= i_hwdata;
         last <= o_hrdata;
         ws <= 1'b0;
         pend <= (i_htrans == 2'h2);
         a <= i_haddr;
         w <= i_hwrite;
         err <= i_haddr[31];
      end else begin
         ws <= 1'b1;
      end
   end
endmodule

// *** dv/dwpef_top_bench.sv ***
// Register-driven bench for width packing, errors and event flags
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module dwpef_top_bench;
   import dwpef_pkg::*;
   // Mem-to-mem, both steps, read memory, enable
   localparam logic [31:0] BASE = 32'h40d1;
   logic clk, rst_b, psel, pen, pwr, slow, serr, rdy, pslverr, hready, hresp;
   logic [7:0] paddr;
   logic [7:0] irq;
   logic [31:0] pwdata, rd, prdata, haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, wsize;
   logic [7:0] ack;
   int n_ack = 0;
   logic hwrite;
   int n_fail = 0;
   int num_checks = 0;
   logic [1:0] mw [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h0};
   logic [1:0] pw [7] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
   logic [31:0] ex [7] = '{32'h000000b0, 32'h0000b1b0, 32'hb1b0b1b0, 32'hb0b0b0b0,
      32'hb1b0b1b0, 32'hb3b2b1b0, 32'hb0b0b0b0};
   dwpef_top dwpef_top_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(rdy),
      .O_PSLVERR(pslverr), .O_HADDR(haddr), .O_HTRANS(htrans), .O_HWRITE(hwrite),
      .O_HSIZE(hsize),
      .O_HWDATA(hwdata), .I_HRDATA(hrdata), .I_HREADY(hready), .I_HRESP(hresp),
      .I_CH_REQ(8'h00), .O_CH_ACK(ack), .O_CH_IRQ(irq));
   dwpef_ahb_mem dwpef_ahb_mem_inst (.clk(clk), .rst_b(rst_b), .i_slow(slow), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hwdata(hwdata), .o_hrdata(hrdata),
      .o_hready(hready), .o_hresp(hresp));
   always #2.5 clk = ~clk;
   // Write size and item acks as the design drives them
   always @(posedge clk) begin
      if (htrans == 2'h2 && hwrite) wsize <= hsize;
      if (ack != 8'h00) n_ack <= n_ack + 1;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Word accesses only
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rdy !== 1'b1 && k < 20);
      if (rdy !== 1'b1) begin
         n_fail++;
         summarize();
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wait_flag(input int b);
      int k;
      k = 0;
      do begin
         apb(1'b0, 8'h00, 32'h0);
         k++;
      end while (rd[b] !== 1'b1 && k < 100);
      if (rd[b] !== 1'b1) begin
         n_fail++;
         summarize();
      end
   endtask
   // Channel 0: memory word 0 to peripheral at 0x20
   task automatic run(input logic [31:0] cfg, input logic [15:0] n);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h0c, {16'h0, n});
      apb(1'b1, 8'h10, 32'h20);
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b1, 8'h08, cfg);
      wait_flag(1);
   endtask
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      {psel, pen, pwr, slow, paddr, pwdata} = '0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 8'hfc, 32'h0);
      `CHK(serr, 1'b1)
      dwpef_ahb_mem_inst.mem[0] = 32'hb3b2b1b0;
      for (int i = 0; i < 7; i++) begin
         dwpef_ahb_mem_inst.mem[8] = 32'h0;
         slow <= i[0];
         run(BASE | {20'h0, mw[i], pw[i], 8'h0}, 16'h1);
         `CHK(dwpef_ahb_mem_inst.mem[8], ex[i])
         `CHK(wsize, {1'b0, pw[i]})
         apb(1'b1, 8'h04, 32'hf);
      end
      run(BASE | 32'h206, 16'h4);
      for (int k = 0; k < 4; k++) `CHK(dwpef_ahb_mem_inst.mem[8 + k], 32'hb0 + k)
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h7)
      `CHK(irq, 8'h01)
      apb(1'b1, 8'h00, 32'hffffffff);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h7)
      apb(1'b1, 8'h04, 32'h4);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h3)
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(irq, 8'h00)
      // Channel 1 writes into reserved space
      apb(1'b1, 8'h20, 32'h1);
      apb(1'b1, 8'h24, 32'h80000020);
      apb(1'b1, 8'h28, 32'h0);
      apb(1'b1, 8'h1c, BASE | 32'h8);
      wait_flag(7);
      `CHK(rd, 32'h90)
      `CHK(irq, 8'h02)
      apb(1'b0, 8'h1c, 32'h0);
      `CHK(rd[0], 1'b0)
      `CHK(n_ack, 11)
      summarize();
   end
endmodule
